// ===== common/bstap_pkg.sv
// Package of constants and types for the boundary-scan test access port.
package bstap_pkg;

  // ----------------------------------------------------------------------
  // Register widths
  // ----------------------------------------------------------------------
  localparam int IR_LEN       = 10;
  localparam int USER_LEN     = 32;
  localparam int DEVICE_IDENTITY_REG_LEN   = 32;
  localparam int BSR_LEN_MIN  = 1317;
  localparam int BSR_LEN_MAX  = 3777;

  // ----------------------------------------------------------------------
  // Identification field layout, most significant field first
  // ----------------------------------------------------------------------
  localparam int ID_VER_LSB   = 28;
  localparam int ID_PART_LSB  = 12;
  localparam int ID_MFR_LSB   = 1;
  localparam int ID_VER_W     = 4;
  localparam int ID_PART_W    = 16;
  localparam int ID_MFR_W     = 11;
  localparam logic ID_LSB_BIT = 1'b1;

  // ----------------------------------------------------------------------
  // Instruction opcodes (10 bits)
  // ----------------------------------------------------------------------
  localparam logic [9:0] OP_EXTEST     = 10'h000;
  localparam logic [9:0] OP_SAMPLE     = 10'h005;
  localparam logic [9:0] OP_DEVICE_IDENTITY_REG     = 10'h006;
  localparam logic [9:0] OP_USER_CODE_REG   = 10'h007;
  localparam logic [9:0] OP_CLAMP      = 10'h00A;
  localparam logic [9:0] OP_HIGHZ      = 10'h00B;
  localparam logic [9:0] OP_ICR_LOAD   = 10'h002;
  localparam logic [9:0] OP_ICR_START  = 10'h003;
  localparam logic [9:0] OP_RESTART    = 10'h001;
  localparam logic [9:0] OP_CONFIG_IO  = 10'h00D;
  localparam logic [9:0] OP_ANALYZER   = 10'h00E;
  localparam logic [9:0] OP_BYPASS     = 10'h3FF;
  localparam logic [1:0] IR_CAPTURE    = 2'h1;

  // Reset values.
  localparam logic       BYPASS_RST    = 1'b0;
  localparam logic       TDO_RST       = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_DR_SEL, ST_DR_CAP, ST_DR_SHIFT, ST_DR_EX1,
    ST_DR_PAUSE, ST_DR_EX2, ST_DR_UPD, ST_IR_SEL, ST_IR_CAP,
    ST_IR_SHIFT, ST_IR_EX1, ST_IR_PAUSE, ST_IR_EX2, ST_IR_UPD
  } bstap_state_t;

  typedef enum logic [2:0] {
    SEL_BYPASS, SEL_DEVICE_IDENTITY_REG, SEL_USER, SEL_BSR, SEL_CFG, SEL_ANALYZER
  } bstap_sel_t;

endpackage

// ===== design/bstap_top.sv
// Boundary-scan test access port with instruction decode and data registers.
`timescale 1ns/1ns
`default_nettype none

module bstap_top
  import bstap_pkg::*;
#(
  parameter int              NUM_PINS  = 8,
  parameter int              PLL_BITS  = 4,
  parameter int              IOSTD_W   = 2,
  parameter logic [3:0]      ID_VER    = 4'h1,    // Arbitrary value.
  parameter logic [15:0]     ID_PART   = 16'h1234, // Arbitrary value.
  parameter logic [10:0]     ID_MFR    = 11'h055,  // Arbitrary value.
  parameter logic [31:0]     USER_CODE = 32'hFFFF_FFFF,
  parameter int              ANA_W     = 8
) (
  input  wire logic                          clk_sys_in,
  input  wire logic                          resetn_in,
  input  wire logic                          tck_in,
  input  wire logic                          tms_in,
  input  wire logic                          tdi_in,
  input  wire logic                          trstn_in,
  output logic                               tdo_out,
  output logic                               tdo_oe_out,
  input  wire logic                          powered_in,
  input  wire logic                          cfg_busy_in,
  input  wire logic                          cfg_done_in,
  input  wire logic [NUM_PINS-1:0]           pin_in,
  input  wire logic [NUM_PINS-1:0]           core_out_in,
  input  wire logic [NUM_PINS-1:0]           core_oe_in,
  input  wire logic [NUM_PINS-1:0]           hold_en_in,
  input  wire logic [ANA_W-1:0]              analyzer_in,
  output logic [NUM_PINS-1:0]                pin_out,
  output logic [NUM_PINS-1:0]                pin_oe_out,
  output logic [NUM_PINS-1:0]                pin_keep_out,
  output logic [NUM_PINS*IOSTD_W-1:0]        io_std_out,
  output logic [PLL_BITS-1:0]                pll_bits_out,
  output logic                               cfg_restart_out,
  output logic                               cfg_abort_out,
  output logic                               cfg_data_valid_out,
  output logic                               cfg_data_out,
  output logic                               cfg_start_out
);

  // Scan register: per pin a capture/shift cell (pin value, oe), then I/O standards,
  // then the PLL bits while not configured.
  localparam int BSR_W = 2 * NUM_PINS;
  localparam int CFG_W = NUM_PINS * IOSTD_W;
  localparam logic [31:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, ID_LSB_BIT};

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       tck_prev_q;

  // Every link pin passes two flops; only the second stage is read.
  // Reset loads the idle pin levels, so no false TCK edge follows reset.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sync1_q    <= 4'hA;
      sync2_q    <= 4'hA;
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {trstn_in, tck_in, tms_in, tdi_in};
      sync2_q    <= sync1_q;
      tck_prev_q <= sync2_q[2];
    end
  end

  logic tdi_s;
  logic tms_s;
  logic tck_s;
  logic trstn_s;
  logic tck_rise;
  logic tck_fall;
  assign tdi_s    = sync2_q[0];
  assign tms_s    = sync2_q[1];
  assign tck_s    = sync2_q[2];
  assign trstn_s  = sync2_q[3];
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ----------------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------------
  bstap_state_t state_q;
  bstap_state_t state_d;

  // Standard sixteen-state walk, taken on rising TCK.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:    state_d = tms_s ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_d = tms_s ? ST_DR_SEL   : ST_IDLE;
      ST_DR_SEL:   state_d = tms_s ? ST_IR_SEL   : ST_DR_CAP;
      ST_DR_CAP:   state_d = tms_s ? ST_DR_EX1   : ST_DR_SHIFT;
      ST_DR_SHIFT: state_d = tms_s ? ST_DR_EX1   : ST_DR_SHIFT;
      ST_DR_EX1:   state_d = tms_s ? ST_DR_UPD   : ST_DR_PAUSE;
      ST_DR_PAUSE: state_d = tms_s ? ST_DR_EX2   : ST_DR_PAUSE;
      ST_DR_EX2:   state_d = tms_s ? ST_DR_UPD   : ST_DR_SHIFT;
      ST_DR_UPD:   state_d = tms_s ? ST_DR_SEL   : ST_IDLE;
      ST_IR_SEL:   state_d = tms_s ? ST_RESET    : ST_IR_CAP;
      ST_IR_CAP:   state_d = tms_s ? ST_IR_EX1   : ST_IR_SHIFT;
      ST_IR_SHIFT: state_d = tms_s ? ST_IR_EX1   : ST_IR_SHIFT;
      ST_IR_EX1:   state_d = tms_s ? ST_IR_UPD   : ST_IR_PAUSE;
      ST_IR_PAUSE: state_d = tms_s ? ST_IR_EX2   : ST_IR_PAUSE;
      ST_IR_EX2:   state_d = tms_s ? ST_IR_UPD   : ST_IR_SHIFT;
      ST_IR_UPD:   state_d = tms_s ? ST_DR_SEL   : ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= ST_RESET;
    end else if (!trstn_s) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction register and decode
  // ----------------------------------------------------------------------
  logic [IR_LEN-1:0] ir_shift_q;
  logic [IR_LEN-1:0] instruction_reg_q;

  // Capture loads the fixed 01 pattern; reset selects the identity register.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ir_shift_q        <= OP_DEVICE_IDENTITY_REG;
      instruction_reg_q <= OP_DEVICE_IDENTITY_REG;
    end else if (!trstn_s || (tck_rise && state_q == ST_RESET)) begin
      instruction_reg_q <= OP_DEVICE_IDENTITY_REG;
    end else if (tck_rise) begin
      if (state_q == ST_IR_CAP) begin
        ir_shift_q <= {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
      end else if (state_q == ST_IR_SHIFT) begin
        ir_shift_q <= {tdi_s, ir_shift_q[IR_LEN-1:1]};
      end else if (state_q == ST_IR_UPD) begin
        instruction_reg_q <= ir_shift_q;
      end
    end
  end

  bstap_sel_t sel;
  logic       scan_test;
  logic       in_config;
  assign in_config = cfg_busy_in & ~cfg_done_in;

  // Scan tests that touch the pins are refused while configuration runs.
  always_comb begin
    sel       = SEL_BYPASS;
    scan_test = 1'b0;
    unique case (instruction_reg_q)
      OP_DEVICE_IDENTITY_REG:    sel = SEL_DEVICE_IDENTITY_REG;
      OP_USER_CODE_REG:  sel = SEL_USER;
      OP_SAMPLE:    sel = SEL_BSR;
      OP_EXTEST: begin
        sel       = in_config ? SEL_BYPASS : SEL_BSR;
        scan_test = ~in_config;
      end
      OP_CLAMP:     scan_test = ~in_config;
      OP_HIGHZ:     scan_test = ~in_config;
      OP_CONFIG_IO: sel = SEL_BSR;
      OP_ICR_LOAD:  sel = SEL_CFG;
      OP_ANALYZER:  sel = SEL_ANALYZER;
      default:      sel = SEL_BYPASS;
    endcase
  end

  // ----------------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------------
  logic                      bypass_reg_q;
  logic [DEVICE_IDENTITY_REG_LEN-1:0]     id_shift_q;
  logic [BSR_W-1:0]          bsr_shift_q;
  logic [BSR_W-1:0]          bsr_upd_q;
  logic [CFG_W-1:0]          std_shift_q;
  logic [CFG_W-1:0]          std_upd_q;
  logic [PLL_BITS-1:0]       pll_shift_q;
  logic [PLL_BITS-1:0]       pll_upd_q;
  logic [ANA_W-1:0]          ana_shift_q;
  logic                      pll_in_chain;
  logic                      dr_cap;
  logic                      dr_sh;
  logic                      dr_upd;
  assign pll_in_chain = powered_in & ~cfg_done_in;
  assign dr_cap = tck_rise && state_q == ST_DR_CAP;
  assign dr_sh  = tck_rise && state_q == ST_DR_SHIFT;
  assign dr_upd = tck_rise && state_q == ST_DR_UPD;

  // Scan chain order is TDI, PLL bits (if present), I/O standards, pin cells, TDO.
  logic chain_mid;
  assign chain_mid = pll_in_chain ? pll_shift_q[0] : tdi_s;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      bypass_reg_q <= BYPASS_RST;
      id_shift_q   <= '0;
      ana_shift_q  <= '0;
    end else if (dr_cap) begin
      bypass_reg_q <= 1'b0;
      id_shift_q   <= (sel == SEL_USER) ? USER_CODE : ID_VALUE;
      ana_shift_q  <= analyzer_in;
    end else if (dr_sh) begin
      bypass_reg_q <= tdi_s;
      id_shift_q   <= {tdi_s, id_shift_q[DEVICE_IDENTITY_REG_LEN-1:1]};
      ana_shift_q  <= {tdi_s, ana_shift_q[ANA_W-1:1]};
    end
  end

  // Pin cells capture the pins; the update stage holds the driven pattern.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      bsr_shift_q <= '0;
      bsr_upd_q   <= '0;
      std_shift_q <= '0;
      std_upd_q   <= '0;
      pll_shift_q <= '0;
      pll_upd_q   <= '0;
    end else if (sel == SEL_BSR) begin
      if (dr_cap) begin
        bsr_shift_q <= {core_oe_in, pin_in};
      end else if (dr_sh) begin
        pll_shift_q <= {tdi_s, pll_shift_q[PLL_BITS-1:1]};
        std_shift_q <= {chain_mid, std_shift_q[CFG_W-1:1]};
        bsr_shift_q <= {std_shift_q[0], bsr_shift_q[BSR_W-1:1]};
      end else if (dr_upd) begin
        bsr_upd_q <= bsr_shift_q;
        if (instruction_reg_q == OP_CONFIG_IO) begin
          std_upd_q <= std_shift_q;
        end
        if (pll_in_chain) begin
          pll_upd_q <= pll_shift_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration side effects
  // ----------------------------------------------------------------------
  // One-cycle pulses, plus cfg_data_out following TDI every clock; the real restart pin is never touched here.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cfg_restart_out    <= 1'b0;
      cfg_abort_out      <= 1'b0;
      cfg_data_valid_out <= 1'b0;
      cfg_data_out       <= 1'b0;
      cfg_start_out      <= 1'b0;
    end else begin
      cfg_restart_out    <= tck_rise && state_q == ST_IDLE
                            && instruction_reg_q == OP_RESTART;
      cfg_abort_out      <= tck_rise && state_q == ST_IR_UPD
                            && ir_shift_q == OP_CONFIG_IO && in_config;
      cfg_data_valid_out <= dr_sh && sel == SEL_CFG;
      cfg_data_out       <= tdi_s;
      cfg_start_out      <= tck_rise && state_q == ST_IDLE
                            && instruction_reg_q == OP_ICR_START;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  logic                 highz;
  logic                 drive_bsr;
  assign highz     = instruction_reg_q == OP_HIGHZ && scan_test;
  assign drive_bsr = (instruction_reg_q == OP_EXTEST || instruction_reg_q == OP_CLAMP)
                     && scan_test;

  // Pins are released until the supply is good, then driven by EXTEST or CLAMP outside configuration, or by the core once configured.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_out      <= '0;
      pin_oe_out   <= '0;
      pin_keep_out <= '0;
      io_std_out   <= '0;
      pll_bits_out <= '0;
    end else begin
      io_std_out   <= std_upd_q;
      pll_bits_out <= pll_upd_q;
      if (!powered_in) begin
        pin_out    <= '0;
        pin_oe_out <= '0;
      end else if (highz) begin
        pin_out    <= '0;
        pin_oe_out <= '0;
      end else if (drive_bsr) begin
        pin_out    <= bsr_upd_q[NUM_PINS-1:0];
        pin_oe_out <= bsr_upd_q[BSR_W-1:NUM_PINS];
      end else if (cfg_done_in) begin
        pin_out    <= core_out_in;
        pin_oe_out <= core_oe_in;
      end else begin
        pin_out    <= '0;
        pin_oe_out <= '0;
      end
      // Keeper wins over any undriven state from scan modes.
      pin_keep_out <= powered_in ? hold_en_in : '0;
    end
  end

  // ----------------------------------------------------------------------
  // TDO, updated on falling TCK
  // ----------------------------------------------------------------------
  logic tdo_d;
  always_comb begin
    tdo_d = bypass_reg_q;
    if (state_q == ST_IR_SHIFT) begin
      tdo_d = ir_shift_q[0];
    end else begin
      unique case (sel)
        SEL_DEVICE_IDENTITY_REG, SEL_USER: tdo_d = id_shift_q[0];
        SEL_BSR:              tdo_d = bsr_shift_q[0];
        SEL_ANALYZER:         tdo_d = ana_shift_q[0];
        SEL_CFG, SEL_BYPASS:  tdo_d = bypass_reg_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      tdo_out    <= TDO_RST;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= tdo_d;
      tdo_oe_out <= powered_in &&
                    (state_q == ST_IR_SHIFT || state_q == ST_DR_SHIFT);
    end
  end

  // Scan register length is a per-device figure; this instance is scaled down.
  localparam int BSR_FULL = BSR_LEN_MIN;

endmodule // bstap_top

`default_nettype wire

// ===== bench/bstap_checker.sv
// Concurrent checks on the pins of the scan port top module.
`timescale 1ns/1ns
`default_nettype none

module bstap_checker #(
  parameter int NUM_PINS = 8
) (
  input wire logic                clk_sys_in,
  input wire logic                resetn_in,
  input wire logic                tck_in,
  input wire logic                powered_in,
  input wire logic                cfg_busy_in,
  input wire logic                tdo_out,
  input wire logic                tdo_oe_out,
  input wire logic [NUM_PINS-1:0] pin_oe_out,
  input wire logic                cfg_restart_out,
  input wire logic                cfg_abort_out,
  input wire logic                cfg_data_valid_out
);
  // ----------------------------------------------------------------------
  // Timing frame
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // Two edges of reset give the registers one edge to clear.
  sequence s_rst;
    !resetn_in ##1 !resetn_in;
  endsequence

  // Power lost over two edges, enough for the output registers.
  sequence s_unpowered;
    !powered_in ##1 !powered_in;
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // TCK is synchronised, so an edge shows two clocks late at the earliest.
  tdo_fall_a: assert property ($changed(tdo_out) |-> !$past(tck_in, 2))
    else $error("serial output moved outside the low phase of TCK");
  oe_fall_a: assert property ($changed(tdo_oe_out) |-> !$past(tck_in, 2))
    else $error("serial output enable moved outside the low phase of TCK");
  rst_quiet_a: assert property (disable iff (1'b0) s_rst |-> !tdo_oe_out && pin_oe_out == '0)
    else $error("output driven while reset held");
  power_quiet_a: assert property (s_unpowered |-> pin_oe_out == '0)
    else $error("pin driven without power");
  restart_pulse_a: assert property (cfg_restart_out |=> !cfg_restart_out [*8])
    else $error("restart strobe longer than one clock");
  abort_cause_a: assert property (cfg_abort_out |-> cfg_busy_in || $past(cfg_busy_in))
    else $error("abort strobe outside configuration");
  abort_pulse_a: assert property (cfg_abort_out |=> !cfg_abort_out [*8])
    else $error("abort strobe longer than one clock");
  data_pulse_a: assert property (cfg_data_valid_out |=> !cfg_data_valid_out [*6])
    else $error("more than one load strobe per scan clock");
endmodule // bstap_checker

bind bstap_top bstap_checker #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .tck_in(tck_in),
  .powered_in(powered_in), .cfg_busy_in(cfg_busy_in), .tdo_out(tdo_out),
  .tdo_oe_out(tdo_oe_out), .pin_oe_out(pin_oe_out), .cfg_restart_out(cfg_restart_out),
  .cfg_abort_out(cfg_abort_out), .cfg_data_valid_out(cfg_data_valid_out));
`default_nettype wire

// ===== bench/bstap_host.sv
// Model of the board test controller that drives the scan port pins.
`timescale 1ns/1ns
`default_nettype none

module bstap_host (
  input  wire logic clk_sys_in,
  input  wire logic tdo_in,
  output var logic  tck_out,
  output var logic  tms_out,
  output var logic  tdi_out,
  output var logic  trstn_out
);
  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // TCK stands low between frames.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trstn_out = 1'b1;
  end

  // One bit is 80 ns; TMS and TDI hold across the rise, and TDO is taken just
  // before the fall, where it still shows what the rise saw.
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk_sys_in);
    tms_out <= m;
    tdi_out <= d;
    repeat (3) @(posedge clk_sys_in);
    tck_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    o = tdo_in;
    tck_out <= 1'b0;
  endtask

  // TMS bits LSB first; TDI toggles so an idle value is never trusted.
  task automatic walk(input logic [7:0] p, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(p[i], ~tdi_out, o);
    end
  endtask

  // From idle: selects the IR or DR path, shifts n bits LSB first, back to idle.
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    walk(8'h01, 2);
    // Updates land a few clocks after the last rise; let them settle.
    repeat (2) @(posedge clk_sys_in);
  endtask

  // Five TMS highs reach reset from any state, then one low to idle.
  task automatic tap_reset;
    walk(8'h1F, 6);
  endtask

  // Reset through the dedicated pin, then to idle.
  task automatic pin_reset;
    @(posedge clk_sys_in);
    trstn_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    trstn_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    walk(8'h00, 1);
  endtask
endmodule // bstap_host
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import bstap_pkg::*;
  // ----------------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------------
  localparam int          NP = 8;
  localparam int          PB = 4;
  localparam int          LN = NP * 2 + 2 * NP;
  localparam logic [31:0] UC = 32'hA5C3_0F96;
  localparam logic [31:0] ID = {4'h3, 16'h5A5A, 11'h2B7, 1'b1}; // Arbitrary fields.
  logic                   clk, rstn, tck, tms, tdi, trstn, tdo, pwr, busy, done, rs, ab, dv, db;
  logic                   st;
  logic [PB-1:0]          pll;
  logic [NP-1:0]          pin, co, coe, hold, po, poe, keep;
  logic [2*NP-1:0]        iostd;
  logic [127:0]           q;
  int                     err_total, checked, n_rs, n_ab, n_dv, n_one, n_st;

  bstap_top #(.ID_VER(ID[31:28]), .ID_PART(ID[27:12]), .ID_MFR(ID[11:1]), .USER_CODE(UC))
  u_dut (
    .clk_sys_in(clk), .resetn_in(rstn), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .trstn_in(trstn), .tdo_out(tdo), .tdo_oe_out(), .powered_in(pwr), .cfg_busy_in(busy),
    .cfg_done_in(done), .pin_in(pin), .core_out_in(co), .core_oe_in(coe), .hold_en_in(hold),
    .analyzer_in(8'h5A), .pin_out(po), .pin_oe_out(poe), .pin_keep_out(keep),
    .io_std_out(iostd), .pll_bits_out(pll), .cfg_restart_out(rs), .cfg_abort_out(ab),
    .cfg_data_valid_out(dv), .cfg_data_out(db), .cfg_start_out(st));

  bstap_host u_host (.clk_sys_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
                     .tdi_out(tdi), .trstn_out(trstn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Strobes are one clock wide, so counting them catches doubles and misses.
  always @(posedge clk) begin
    if (rs === 1'b1) n_rs++;
    if (ab === 1'b1) n_ab++;
    if (dv === 1'b1) n_dv++;
    if (dv === 1'b1 && db === 1'b1) n_one++;
    if (st === 1'b1) n_st++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ir(input logic [9:0] op);
    u_host.scan(1'b1, IR_LEN, 128'(op), q);
    chk("ir capture", 32'(IR_CAPTURE), 32'(q[1:0]));
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_ident;
    u_host.scan(1'b0, 32, '0, q);
    chk("device_identity_reg", ID, q[31:0]);
    ir(OP_USER_CODE_REG);
    u_host.scan(1'b0, 33, 128'h1, q);
    chk("user_code_reg", UC, q[31:0]);
    chk("user_code_reg length", 32'h1, 32'(q[32]));
    u_host.pin_reset();
    u_host.scan(1'b0, 32, '0, q);
    chk("device_identity_reg after pin reset", ID, q[31:0]);
    $display("test ident done");
  endtask

  // The bypass bit captures zero, then delays the stream by one bit.
  task automatic t_bypass;
    ir(OP_BYPASS);
    u_host.scan(1'b0, 8, 128'hB5, q);
    chk("bypass", 32'h6A, 32'(q[7:0]));
    ir(10'h155);
    u_host.scan(1'b0, 8, 128'hB5, q);
    chk("unknown opcode", 32'h6A, 32'(q[7:0]));
    $display("test bypass done");
  endtask

  // Uniform patterns keep the checks free of the chain's cell order.
  task automatic t_pins;
    ir(OP_SAMPLE);
    u_host.scan(1'b0, LN, '1, q);
    chk("sample capture", 32'hFFFF, 32'(q[2*NP-1:0]));
    chk("sample leaves pins", 32'(co), 32'(po));
    ir(OP_EXTEST);
    chk("extest pins", 32'hFF, 32'(po));
    chk("extest enables", 32'hFF, 32'(poe));
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    chk("unpowered enables", 32'h0, 32'(poe));
    pwr <= 1'b1;
    ir(OP_CLAMP);
    u_host.scan(1'b0, 2, 128'h1, q);
    chk("clamp path", 32'h2, 32'(q[1:0]));
    chk("clamp pins", 32'hFF, 32'(po));
    ir(OP_HIGHZ);
    chk("highz enables", 32'h0, 32'(poe));
    chk("highz keepers", 32'(hold), 32'(keep));
    $display("test pins done");
  endtask

  // A lone one comes out after exactly as many bits as the chain holds.
  task automatic t_chain;
    done <= 1'b0;
    ir(OP_SAMPLE);
    u_host.scan(1'b0, 2 * (LN + PB), 128'h1, q);
    chk("chain before config", 32'h1, 32'(q[LN+PB]));
    u_host.scan(1'b0, LN + PB, '1, q);
    chk("pll bits loaded", 32'hF, 32'(pll));
    done <= 1'b1;
    u_host.scan(1'b0, 2 * LN, 128'h1, q);
    chk("chain after config", 32'h1, 32'(q[LN]));
    chk("pll bits kept", 32'hF, 32'(pll));
    $display("test chain done");
  endtask

  task automatic t_config;
    n_ab = 0;
    n_rs = 0;
    ir(OP_CONFIG_IO);
    u_host.scan(1'b0, LN + PB, '1, q);
    chk("io standards", 32'hFFFF, 32'(iostd));
    chk("no abort in user mode", 32'h0, 32'(n_ab));
    // The restart fires on a TCK in idle, which the next load supplies.
    ir(OP_RESTART);
    busy <= 1'b1;
    done <= 1'b0;
    ir(OP_CONFIG_IO);
    chk("restart strobes", 32'h1, 32'(n_rs));
    chk("abort strobes", 32'h1, 32'(n_ab));
    ir(OP_EXTEST);
    u_host.scan(1'b0, 2, 128'h1, q);
    chk("scan refused in config", 32'h2, 32'(q[1:0]));
    busy <= 1'b0;
    n_dv = 0;
    n_one = 0;
    ir(OP_ICR_LOAD);
    u_host.scan(1'b0, 8, 128'hB4, q);
    chk("load strobes", 32'h8, 32'(n_dv));
    chk("load ones", 32'h4, 32'(n_one));
    ir(OP_ICR_START);
    u_host.walk(8'h00, 1);
    repeat (2) @(posedge clk);
    chk("start strobes", 32'h1, 32'(n_st));
    $display("test config done");
  endtask

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {rstn, busy} = 2'b00;
    {pwr, done} = 2'b11;
    {pin, coe} = '1;
    co = 8'h96;
    hold = 8'h3C;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    u_host.tap_reset();
    t_ident();
    t_bypass();
    t_pins();
    t_chain();
    t_config();
    test_done();
  end

  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
